// File: src/tspcs_pkg.sv
// tspcs_pkg: constants, register map and carrier types for the timestamp block
// assumes a 125 MHz ref_clk and an APB slave with 32-bit data
package tspcs_pkg;

	localparam int unsigned CLK_MHZ     = 125;
	localparam int unsigned CLK_PER_NS  = 8;
	localparam int unsigned INT_TICK_US = 1;
	localparam int unsigned PTP_TICK_NS = 8;
	localparam int unsigned INT_DIV     = INT_TICK_US * CLK_MHZ;
	localparam int unsigned PTP_DIV     = (PTP_TICK_NS + CLK_PER_NS - 1) / CLK_PER_NS;
	localparam int unsigned ELECT_MS    = 2000;
	localparam int unsigned ELECT_CYC   = ELECT_MS * 1000 * CLK_MHZ;

	localparam logic [15:0] EUI_FILL = 16'hFFFE;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_CMD     = 8'h04;
	localparam logic [7:0] OFS_STAT    = 8'h08;
	localparam logic [7:0] OFS_IRQ     = 8'h0C;
	localparam logic [7:0] OFS_MASK    = 8'h10;
	localparam logic [7:0] OFS_MODULO  = 8'h14;
	localparam logic [7:0] OFS_VAL_LO  = 8'h18;
	localparam logic [7:0] OFS_VAL_HI  = 8'h1C;
	localparam logic [7:0] OFS_CAP_LO  = 8'h20;
	localparam logic [7:0] OFS_CAP_HI  = 8'h24;
	localparam logic [7:0] OFS_MAC_LO  = 8'h28;
	localparam logic [7:0] OFS_MAC_HI  = 8'h2C;
	localparam logic [7:0] OFS_PEER_LO = 8'h30;
	localparam logic [7:0] OFS_PEER_HI = 8'h34;
	localparam logic [7:0] OFS_CID_LO  = 8'h38;
	localparam logic [7:0] OFS_CID_HI  = 8'h3C;
	localparam logic [7:0] OFS_EVT_ID0 = 8'h40;
	localparam int unsigned NUM_EVT    = 20;

	// control bits
	localparam int unsigned CTRL_PTP  = 0;
	localparam int unsigned CTRL_TRIG = 1;
	localparam int unsigned CTRL_SRCM = 2;
	// command bits
	localparam int unsigned CMD_CLR = 0;
	localparam int unsigned CMD_CAP = 1;
	// irq bits
	localparam int unsigned IRQ_MOD   = 0;
	localparam int unsigned IRQ_ELECT = 1;
	localparam int unsigned IRQ_W     = 2;

	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] MODULO_RST = 32'h0000_0000;
	localparam logic [15:0] EVT_ID_BASE = 16'h9000; // arbitrary

	typedef enum logic [1:0] {
		ROLE_IDLE,
		ROLE_ELECT,
		ROLE_MASTER,
		ROLE_SLAVE
	} tspcs_role_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tspcs_apb_s;

	typedef struct packed {
		logic [63:0] intCount;
		logic [63:0] ptpCount;
	} tspcs_cnt_s;

endpackage

// File: src/tspcs_counters.sv
// tspcs_counters: internal 1 us and precision 8 ns timestamp counters
// assumes clr pulses come from the register file, one cycle each
module tspcs_counters (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              precision_sync_mode,
	input  wire logic              clrCmd,
	output tspcs_pkg::tspcs_cnt_s  cnt
);
	import tspcs_pkg::*;

	logic [6:0]  divQ, divD;
	tspcs_cnt_s  cntQ, cntD;
	logic        usTick;

	assign usTick = (divQ == 7'(INT_DIV - 1));
	assign cnt    = cntQ;

	always_comb begin
		divD = usTick ? 7'h00 : divQ + 7'h01;
		cntD = cntQ;
		if (usTick) begin
			cntD.intCount = cntQ.intCount + 64'h1; // [R06]
		end
		cntD.ptpCount = cntQ.ptpCount + 64'(PTP_TICK_NS); // [R07]
		if (clrCmd) begin
			cntD.intCount = 64'h0; // [R08]
			if (!precision_sync_mode) begin
				cntD.ptpCount = 64'h0; // [R15]
			end
		end
		if (clrCmd && !usTick) begin
			divD = 7'h00;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			divQ <= 7'h00;
			cntQ <= '0;
		end else begin
			divQ <= divD;
			cntQ <= cntD;
		end
	end
endmodule

// File: src/tspcs_elect.sv
// tspcs_elect: master/slave election from own and best peer MAC
// assumes the peer MAC and its valid flag are kept current by the network stack
module tspcs_elect #(
	parameter int unsigned ELECT_CYCLES = tspcs_pkg::ELECT_CYC
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               enable,
	input  wire logic [47:0]        ownMac,
	input  wire logic [47:0]        peerMac,
	input  wire logic               peerValid,
	output tspcs_pkg::tspcs_role_e  role,
	output logic                    done
);
	import tspcs_pkg::*;

	tspcs_role_e roleQ, roleD;
	logic [31:0] tmrQ, tmrD;
	logic        doneQ, doneD;

	assign role = roleQ;
	assign done = doneQ;

	always_comb begin
		roleD = roleQ;
		tmrD  = tmrQ;
		doneD = 1'b0;
		case (roleQ)
			ROLE_IDLE: begin
				tmrD = 32'h0;
				if (enable) begin
					roleD = ROLE_ELECT;
				end
			end
			ROLE_ELECT: begin
				tmrD = tmrQ + 32'h1;
				// decision bounded by the window
				if (tmrQ == 32'(ELECT_CYCLES - 1)) begin // [R03]
					doneD = 1'b1;
					roleD = (!peerValid || ownMac < peerMac) ? ROLE_MASTER : ROLE_SLAVE; // [R02]
				end
			end
			ROLE_MASTER, ROLE_SLAVE: begin
				// a vanished peer leaves this node the lowest address present
				roleD = (!peerValid || ownMac < peerMac) ? ROLE_MASTER : ROLE_SLAVE; // [R02]
			end
			default: roleD = ROLE_IDLE;
		endcase
		if (!enable) begin
			roleD = ROLE_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			roleQ <= ROLE_IDLE;
			tmrQ  <= 32'h0;
			doneQ <= 1'b0;
		end else begin
			roleQ <= roleD;
			tmrQ  <= tmrD;
			doneQ <= doneD;
		end
	end
endmodule

// File: src/tspcs_top.sv
// tspcs_top: timestamp source select, precision clock identity, modulo event, APB registers
// assumes an APB master on ref_clk; peer MAC supplied by the network side
////////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the register addresses and the APB interface to the registers.

// Functional notes
// [R01] clock identity is MAC upper three octets, FFFE, then lower three octets
// [R02] lowest MAC among equal nodes becomes master, others become slaves
// [R03] election decides within about two seconds of enabling precision mode
// [R04] enabling precision mode switches timestamp source to the precision counter
// [R05] precision counter is not cleared by user clear while it is source
// [R06] internal counter advances once every microsecond
// [R07] precision counter advances in eight nanosecond ticks
// [R08] both count always; clear zeros active one, only internal in precision mode
// [R09] fixed read-only identifier per event type
// [R10] modulo interval of 1e9 nanoseconds of precision count gives one event per second
// [R11] with trigger enabled and modulo source, each modulo event starts acquisition
// [R12] modulo interval zero disables modulo event generation
// [R13] timestamp counter is 64 bits and readable
// [R14] capture command copies internal counter into readable holding value
// [R15] reset command sets timestamp counter to zero
module tspcs_top #(
	parameter int unsigned ELECT_CYCLES = tspcs_pkg::ELECT_CYC
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic [47:0]  peerMac,
	input  wire logic         peerValid,
	output logic              acqStart,
	output logic              isMaster,
	output logic              irq
);
	import tspcs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state

	tspcs_apb_s  apb;
	tspcs_cnt_s  cnt;
	tspcs_role_e role;
	logic        electDone;

	logic [31:0] ctrlQ, ctrlD;
	logic [31:0] moduloQ, moduloD;
	logic [47:0] macQ, macD;
	logic [63:0] capQ, capD;
	logic [IRQ_W-1:0] irqStQ, irqStD;
	logic [IRQ_W-1:0] maskQ, maskD;
	logic [31:0] modCntQ, modCntD;
	logic [31:0] prdataQ, prdataD;
	logic        preadyQ, preadyD;
	logic        slverrQ, slverrD;
	logic        acqQ, acqD;
	logic        masterQ, masterD;
	logic        irqQ, irqD;
	logic        clrPulse;
	logic        modEvt;
	logic        wrEn;
	logic        rdEn;
	logic [63:0] activeCount;
	logic [63:0] clockId;
	logic        srcMod;
	logic        precision_sync_mode;

	assign apb = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	assign wrEn = apb.psel && apb.penable && apb.pwrite && !preadyQ;
	assign rdEn = apb.psel && apb.penable && !apb.pwrite && !preadyQ;

	assign precision_sync_mode = ctrlQ[CTRL_PTP];
	assign srcMod  = ctrlQ[CTRL_SRCM];
	assign clockId = {macQ[47:24], EUI_FILL, macQ[23:0]}; // [R01]
	// source follows mode; no separate select to fall out of step
	assign activeCount = precision_sync_mode ? cnt.ptpCount : cnt.intCount; // [R04] [R13]

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// sub-blocks

	// clear only reaches the precision counter when mode is off
	assign clrPulse = wrEn && hit(apb.paddr, OFS_CMD) && apb.pwdata[CMD_CLR]; // [R05]

	tspcs_counters u_counters (
		.ref_clk (ref_clk),
		.rst     (rst),
		.precision_sync_mode (precision_sync_mode),
		.clrCmd  (clrPulse),
		.cnt     (cnt)
	);

	tspcs_elect #(
		.ELECT_CYCLES (ELECT_CYCLES)
	) u_elect (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.enable    (precision_sync_mode),
		.ownMac    (macQ),
		.peerMac   (peerMac),
		.peerValid (peerValid),
		.role      (role),
		.done      (electDone)
	);

	////////////////////////////////////////////////////////////////////////////
	// modulo event generator

	// one step per change of the internal count
	logic [63:0] intPrevQ;
	logic        intStep;
	assign intStep = (cnt.intCount != intPrevQ);

	always_comb begin
		modCntD = modCntQ;
		modEvt  = 1'b0;
		if (moduloQ == 32'h0) begin
			modCntD = 32'h0; // [R12]
		end else if (precision_sync_mode ? 1'b1 : intStep) begin
			// precision step is 8 per tick, so count in units of the source value, not in ticks
			if (modCntQ + (precision_sync_mode ? 32'(PTP_TICK_NS) : 32'h1) >= moduloQ) begin
				modCntD = 32'h0;
				modEvt  = 1'b1; // [R10]
			end else begin
				modCntD = modCntQ + (precision_sync_mode ? 32'(PTP_TICK_NS) : 32'h1);
			end
		end
		if (clrPulse) begin
			modCntD = 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers and APB

	always_comb begin
		ctrlD   = ctrlQ;
		moduloD = moduloQ;
		macD    = macQ;
		capD    = capQ;
		maskD   = maskQ;
		irqStD  = irqStQ;
		prdataD = prdataQ;
		preadyD = 1'b0;
		slverrD = 1'b0;
		if (wrEn) begin
			preadyD = 1'b1;
			if (hit(apb.paddr, OFS_CTRL)) begin
				ctrlD = apb.pwdata & 32'h0000_0007;
			end else if (hit(apb.paddr, OFS_CMD)) begin
				if (apb.pwdata[CMD_CAP]) begin
					capD = cnt.intCount; // [R14]
				end
			end else if (hit(apb.paddr, OFS_IRQ)) begin
				irqStD = irqStQ & ~apb.pwdata[IRQ_W-1:0];
			end else if (hit(apb.paddr, OFS_MASK)) begin
				maskD = apb.pwdata[IRQ_W-1:0];
			end else if (hit(apb.paddr, OFS_MODULO)) begin
				moduloD = apb.pwdata; // [R10]
			end else if (hit(apb.paddr, OFS_MAC_LO)) begin
				macD[31:0] = apb.pwdata;
			end else if (hit(apb.paddr, OFS_MAC_HI)) begin
				macD[47:32] = apb.pwdata[15:0];
			end else begin
				slverrD = 1'b1;
			end
		end
		if (rdEn) begin
			preadyD = 1'b1;
			prdataD = 32'h0;
			if (apb.paddr >= OFS_EVT_ID0 && apb.paddr < 8'(OFS_EVT_ID0 + 4 * NUM_EVT)
				&& apb.paddr[1:0] == 2'b00) begin
				prdataD = {16'h0, EVT_ID_BASE + 16'(apb.paddr[7:2] - OFS_EVT_ID0[7:2])}; // [R09]
			end else begin
				case (apb.paddr)
					OFS_CTRL:    prdataD = ctrlQ;
					OFS_STAT:    prdataD = {28'h0, electDone, 1'b0, role};
					OFS_IRQ:     prdataD = {30'h0, irqStQ};
					OFS_MASK:    prdataD = {30'h0, maskQ};
					OFS_MODULO:  prdataD = moduloQ;
					OFS_VAL_LO:  prdataD = activeCount[31:0]; // [R13]
					OFS_VAL_HI:  prdataD = activeCount[63:32];
					OFS_CAP_LO:  prdataD = capQ[31:0];
					OFS_CAP_HI:  prdataD = capQ[63:32];
					OFS_MAC_LO:  prdataD = macQ[31:0];
					OFS_MAC_HI:  prdataD = {16'h0, macQ[47:32]};
					OFS_PEER_LO: prdataD = peerMac[31:0];
					OFS_PEER_HI: prdataD = {16'h0, peerMac[47:32]};
					OFS_CID_LO:  prdataD = clockId[31:0];
					OFS_CID_HI:  prdataD = clockId[63:32];
					default:     slverrD = 1'b1;
				endcase
			end
		end
		// set wins over a same-cycle clear
		if (modEvt) begin
			irqStD[IRQ_MOD] = 1'b1;
		end
		if (electDone) begin
			irqStD[IRQ_ELECT] = 1'b1;
		end
		acqD    = modEvt && ctrlQ[CTRL_TRIG] && srcMod; // [R11]
		masterD = (role == ROLE_MASTER); // [R02]
		irqD    = |(irqStD & maskD);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrlQ    <= CTRL_RST;
			moduloQ  <= MODULO_RST;
			macQ     <= 48'h0;
			capQ     <= 64'h0;
			maskQ    <= '0;
			irqStQ   <= '0;
			modCntQ  <= 32'h0;
			intPrevQ <= 64'h0;
			prdataQ  <= 32'h0;
			preadyQ  <= 1'b0;
			slverrQ  <= 1'b0;
			acqQ     <= 1'b0;
			masterQ  <= 1'b0;
			irqQ     <= 1'b0;
		end else begin
			ctrlQ    <= ctrlD;
			moduloQ  <= moduloD;
			macQ     <= macD;
			capQ     <= capD;
			maskQ    <= maskD;
			irqStQ   <= irqStD;
			modCntQ  <= modCntD;
			intPrevQ <= cnt.intCount;
			prdataQ  <= prdataD;
			preadyQ  <= preadyD;
			slverrQ  <= slverrD;
			acqQ     <= acqD;
			masterQ  <= masterD;
			irqQ     <= irqD;
		end
	end

	assign prdata   = prdataQ;
	assign pready   = preadyQ;
	assign pslverr  = slverrQ;
	assign acqStart = acqQ;
	assign isMaster = masterQ;
	assign irq      = irqQ;
endmodule

// File: verif/tspcs_checker.sv
// tspcs_checker: port assertions for tspcs_top
// assumes one ref_clk domain, rst async high; bound at the foot
module tspcs_checker
	import tspcs_pkg::*;
#(
	parameter int unsigned ELECT_CYCLES = 20
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [47:0] peerMac,
	input wire logic        peerValid,
	input wire logic        acqStart,
	input wire logic        isMaster,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] LIM = 16'(ELECT_CYCLES + 8);
	localparam logic [7:0]  EVT_LAST = 8'(OFS_EVT_ID0 + 4 * NUM_EVT - 4);
	logic [31:0] ctrl_q, ctrl_d, mod_q, mod_d, mask_q, mask_d;
	logic [47:0] mac_q, mac_d;
	logic [15:0] lowCnt_q, lowCnt_d, highCnt_q, highCnt_d;
	logic        wrDone, evtHit, trigOk, low, high;
	////////////////////////////////////////////////////////////////////////
	// shadows of software writes, taken at the access edge as the design does
	assign wrDone = psel && penable && !pready && pwrite;
	assign evtHit = paddr >= OFS_EVT_ID0 && paddr <= EVT_LAST;
	assign trigOk = ctrl_q[CTRL_TRIG] && ctrl_q[CTRL_SRCM] && mod_q != 32'h0;
	assign low = ctrl_q[CTRL_PTP] && (!peerValid || mac_q < peerMac);
	assign high = ctrl_q[CTRL_PTP] && peerValid && peerMac < mac_q;
	always_comb begin
		ctrl_d = (wrDone && paddr == OFS_CTRL) ? pwdata : ctrl_q;
		mod_d = (wrDone && paddr == OFS_MODULO) ? pwdata : mod_q;
		mask_d = (wrDone && paddr == OFS_MASK) ? pwdata : mask_q;
		mac_d = mac_q;
		if (wrDone && paddr == OFS_MAC_LO) mac_d[31:0] = pwdata;
		if (wrDone && paddr == OFS_MAC_HI) mac_d[47:32] = pwdata[15:0];
		// saturate so the check stays armed while the state lasts
		lowCnt_d = !low ? 16'h0 : (lowCnt_q == LIM ? LIM : lowCnt_q + 16'h1);
		highCnt_d = !high ? 16'h0 : (highCnt_q == LIM ? LIM : highCnt_q + 16'h1);
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			mod_q <= MODULO_RST;
			mask_q <= 32'h0;
			mac_q <= 48'h0;
			lowCnt_q <= 16'h0;
			highCnt_q <= 16'h0;
		end else begin
			ctrl_q <= ctrl_d;
			mod_q <= mod_d;
			mask_q <= mask_d;
			mac_q <= mac_d;
			lowCnt_q <= lowCnt_d;
			highCnt_q <= highCnt_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_ready_lat; psel && penable && !pready |=> pready; endproperty
	a_ready_lat: assert property (p_ready_lat) else $error("access not answered");
	property p_err_pair; pslverr |-> pready; endproperty
	a_err_pair: assert property (p_err_pair) else $error("error without ready");
	property p_evt_val;
		psel && penable && !pready && !pwrite && evtHit |=> !pslverr &&
			prdata == {16'h0, EVT_ID_BASE + (16'($past(paddr) - OFS_EVT_ID0) >> 2)};
	endproperty
	a_evt_val: assert property (p_evt_val) else $error("event id wrong");
	property p_evt_ro; psel && penable && !pready && pwrite && evtHit |=> pslverr; endproperty
	a_evt_ro: assert property (p_evt_ro) else $error("event id write taken");
	property p_acq_cause; acqStart |-> trigOk || $past(trigOk) || $past(trigOk, 2); endproperty
	a_acq_cause: assert property (p_acq_cause) else $error("acq start unasked");
	property p_acq_pulse; acqStart && mod_q > 32'h10 |=> !acqStart; endproperty
	a_acq_pulse: assert property (p_acq_pulse) else $error("acq start too long");
	property p_elect_low; lowCnt_q == LIM |-> isMaster; endproperty
	a_elect_low: assert property (p_elect_low) else $error("lowest mac not master");
	property p_elect_high; highCnt_q == LIM |-> !isMaster; endproperty
	a_elect_high: assert property (p_elect_high) else $error("higher mac is master");
	property p_irq_mask; irq |-> (mask_q | $past(mask_q)) != 32'h0; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");
	c_acq: cover property (acqStart);
	c_master: cover property ($rose(isMaster));
	c_err: cover property (pslverr);
	c_irq: cover property (irq);
endmodule

bind tspcs_top tspcs_checker #(.ELECT_CYCLES(ELECT_CYCLES)) uChecker (.ref_clk(ref_clk),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.peerMac(peerMac), .peerValid(peerValid), .acqStart(acqStart), .isMaster(isMaster),
	.irq(irq));

// File: verif/tspcs_peer_model.sv
// tspcs_peer_model: best foreign precision-time node as seen by the block
// assumes the bench sets presence and address between clock edges
module tspcs_peer_model (
	input wire logic        ref_clk,
	input wire logic        present,
	input wire logic [47:0] mac,
	output logic [47:0]     peerMac,
	output logic            peerValid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial peerValid = 1'b0;
	initial peerMac = 48'h0;
	// absent node: stale address inverted, never left readable
	always @(posedge ref_clk) begin
		peerValid <= present;
		peerMac <= present ? mac : ~mac;
	end
endmodule

// File: verif/tspcs_tb.sv
// testbench: scenario tasks over APB for tspcs_top
// assumes short election window; peer model on the network side
module testbench;
	import tspcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned ELECT = 20;
	logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, er;
	logic        acqStart, isMaster, irq, peerValid, peerOn;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, a, b;
	logic [47:0] peerMac, peerSet;
	int          errors, numChecks, acqCount;
	tspcs_peer_model peer (.ref_clk(ref_clk), .present(peerOn), .mac(peerSet),
		.peerMac(peerMac), .peerValid(peerValid));
	tspcs_top #(.ELECT_CYCLES(ELECT)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .peerMac(peerMac), .peerValid(peerValid),
		.acqStart(acqStart), .isMaster(isMaster), .irq(irq));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) if (acqStart === 1'b1) acqCount++;
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	task chkTrue(input logic c);
		chk({31'h0, c}, 32'h1);
	endtask
	// answer sampled at the rising edge; released by nba at that same edge
	task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chkTrue(pready === 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task test_regs;
		int k;
		apb(1'b1, OFS_MAC_LO, 32'h2C3D_4E5F);
		apb(1'b1, OFS_MAC_HI, 32'h0000_0A1B);
		apb(1'b0, OFS_CID_HI, 32'h0);
		chk(rd, 32'h0A1B_2CFF);
		apb(1'b0, OFS_CID_LO, 32'h0);
		chk(rd, 32'hFE3D_4E5F);
		for (k = 0; k < NUM_EVT; k++) begin
			apb(1'b0, 8'(OFS_EVT_ID0 + 4 * k), 32'h0);
			chk(rd, {16'h0, EVT_ID_BASE + 16'(k)});
		end
		apb(1'b1, 8'(OFS_EVT_ID0 + 8), 32'h0);
		chkTrue(er === 1'b1);
		apb(1'b0, 8'(OFS_EVT_ID0 + 8), 32'h0);
		chk(rd, {16'h0, EVT_ID_BASE + 16'h2});
		apb(1'b0, 8'hFC, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000);
	endtask
	task test_internal;
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b0, OFS_VAL_LO, 32'h0);
		chkTrue(rd <= 32'h1);
		cyc(1250);
		apb(1'b0, OFS_VAL_LO, 32'h0);
		a = rd;
		chkTrue(a >= 32'hA && a <= 32'hB);
		apb(1'b0, OFS_VAL_HI, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, OFS_CMD, 32'h2);
		apb(1'b0, OFS_CAP_LO, 32'h0);
		b = rd;
		apb(1'b0, OFS_VAL_LO, 32'h0);
		chkTrue(b >= a && rd - b <= 32'h1);
	endtask
	task test_precision;
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b0, OFS_VAL_LO, 32'h0);
		a = rd;
		chkTrue(a > 32'd5000);
		cyc(100);
		apb(1'b0, OFS_VAL_LO, 32'h0);
		b = rd;
		chkTrue(b - a >= 32'd800 && b - a <= 32'd880 && ((b - a) & 32'h7) == 32'h0);
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b0, OFS_VAL_LO, 32'h0);
		chkTrue(rd > b);
		apb(1'b1, OFS_CMD, 32'h2);
		apb(1'b0, OFS_CAP_LO, 32'h0);
		chkTrue(rd <= 32'h1);
	endtask
	task test_elect;
		peerSet <= 48'h0A1B_2C3D_4E60;
		peerOn <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1);
		cyc(ELECT + 10);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({isMaster, rd[1:0]}, 32'h6);
		apb(1'b1, OFS_CTRL, 32'h0);
		peerSet <= 48'h0A1B_2C3D_4E5E;
		apb(1'b1, OFS_CTRL, 32'h1);
		cyc(ELECT + 10);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({isMaster, rd[1:0]}, 32'h3);
		peerOn <= 1'b0;
		cyc(ELECT + 10);
		chkTrue(isMaster === 1'b1);
		apb(1'b0, OFS_IRQ, 32'h0);
		chk(rd & 32'h2, 32'h2);
	endtask
	task test_modulo;
		apb(1'b1, OFS_IRQ, 32'h3);
		apb(1'b1, OFS_MASK, 32'h0);
		apb(1'b1, OFS_MODULO, 32'd800);
		apb(1'b1, OFS_CTRL, 32'h7);
		cyc(300);
		chkTrue(irq === 1'b0);
		apb(1'b0, OFS_IRQ, 32'h0);
		chk(rd & 32'h1, 32'h1);
		apb(1'b1, OFS_MASK, 32'h1);
		cyc(2);
		chkTrue(irq === 1'b1);
		acqCount = 0;
		cyc(1000);
		chkTrue(acqCount >= 9 && acqCount <= 11);
		apb(1'b1, OFS_MODULO, 32'h0);
		apb(1'b1, OFS_IRQ, 32'h1);
		acqCount = 0;
		cyc(300);
		chkTrue(irq === 1'b0 && acqCount == 0);
		apb(1'b1, OFS_MODULO, 32'd800);
		apb(1'b1, OFS_CTRL, 32'h1);
		acqCount = 0;
		cyc(300);
		chkTrue(acqCount == 0);
		chkTrue(irq === 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task finish_test;
		$display("checks %0d errors %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		peerOn = 1'b0;
		peerSet = 48'h0;
		errors = 0;
		numChecks = 0;
		acqCount = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		test_regs();
		test_internal();
		test_precision();
		test_elect();
		test_modulo();
		finish_test();
	end
	// about 3600 cycles expected; seven times that cuts a hang
	initial begin
		#200000;
		errors++;
		finish_test();
	end
endmodule
